// ===== src/cbs_bus_ctrl.sv
// Contract
// - reset release starts interrupt-style start sequence
// - read_not_write stays high during stack cycles
// - start vector fetched from 00fffc and 00fffd
// - overflow_set_input falling edge sets status bit 6
// - opcode_fetch_indicator high only in opcode fetches
// - ready low stalls the processor, enabling stepping
// - both valid lines low means internal cycle
// - program address cycle drives code 01
// - data address cycle drives code 10
// - opcode fetch cycle drives code 11
// - vector_pull_indicator low during last two sequence cycles
`timescale 1ns/1ps
`include "cbs_consts.svh"

module cbs_bus_ctrl #(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ready,
  input wire logic overflow_set_input,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic exec_done,
  input wire logic exec_is_data,
  input wire logic exec_is_write,
  input wire logic [ADDR_W-1:0] exec_addr,
  output logic [ADDR_W-1:0] addr,
  output logic read_not_write,
  output logic data_address_valid,
  output logic program_address_valid,
  output logic opcode_fetch_indicator,
  output logic vector_pull_indicator_n,
  output logic [15:0] program_counter,
  output logic [7:0] opcode,
  output logic [7:0] processor_status
);
  cbs_pkg::cbs_state_t st_q, st_d;
  logic [1:0] cnt_q, cnt_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0] op_q, op_d;
  logic [7:0] vlo_q, vlo_d;
  logic [7:0] p_q, p_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic rnw_q, rnw_d;
  cbs_pkg::cbs_cycle_t cyc_q, cyc_d;
  logic sync_q, sync_d;
  logic vp_n_q, vp_n_d;
  logic ovf_fall;

  // the pin edge reaches the flag four edges after it falls: two sync
  // stages, the compare flop, then the status register itself
  cbs_ovf_sync u_ovf (
    .clk(clk),
    .rst(rst),
    .pin_in(overflow_set_input),
    .fall_pulse(ovf_fall)
  );

  // next cycle selection; ready low freezes all sequencing state
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    pc_d = pc_q;
    op_d = op_q;
    vlo_d = vlo_q;
    // a stall also holds the counter, so a stack walk resumes in place
    if (ready) begin
      unique case (st_q)
        cbs_pkg::CBS_ST_IDLE: begin
          st_d = cbs_pkg::CBS_ST_INTERNAL;
          cnt_d = 2'(`CBS_INT_CYCLES - 1);
        end
        cbs_pkg::CBS_ST_INTERNAL: begin
          if (cnt_q == 2'h0) begin
            st_d = cbs_pkg::CBS_ST_STACK;
            cnt_d = 2'(`CBS_STACK_CYCLES - 1);
          end else begin
            cnt_d = cnt_q - 2'h1;
          end
        end
        cbs_pkg::CBS_ST_STACK: begin
          if (cnt_q == 2'h0) begin
            st_d = cbs_pkg::CBS_ST_VEC_LO;
          end else begin
            cnt_d = cnt_q - 2'h1;
          end
        end
        cbs_pkg::CBS_ST_VEC_LO: begin
          vlo_d = data_in;
          st_d = cbs_pkg::CBS_ST_VEC_HI;
        end
        cbs_pkg::CBS_ST_VEC_HI: begin
          pc_d = {data_in, vlo_q};
          st_d = cbs_pkg::CBS_ST_FETCH;
        end
        cbs_pkg::CBS_ST_FETCH: begin
          op_d = data_in;
          pc_d = pc_q + 16'h0001;
          st_d = cbs_pkg::CBS_ST_EXEC;
        end
        cbs_pkg::CBS_ST_EXEC: begin
          // stand-in execution: bus cycles until done, then the next fetch
          if (exec_done) begin
            st_d = cbs_pkg::CBS_ST_FETCH;
          end
        end
      endcase
    end
  end

  // bus outputs for the cycle that begins at the next edge
  always_comb begin
    addr_d = addr_q;
    rnw_d = 1'b1;
    cyc_d = cbs_pkg::CBS_CYC_INTERNAL;
    vp_n_d = 1'b1;
    unique case (st_d)
      cbs_pkg::CBS_ST_IDLE, cbs_pkg::CBS_ST_INTERNAL: begin
        cyc_d = cbs_pkg::CBS_CYC_INTERNAL;
      end
      cbs_pkg::CBS_ST_STACK: begin
        // stack cycles are dummy reads so memory is never corrupted
        // the walk goes downwards from the stack top, as pushes would
        addr_d = `CBS_STACK_BASE - ADDR_W'(`CBS_STACK_CYCLES - 1) + ADDR_W'(cnt_d);
        rnw_d = 1'b1;
        cyc_d = cbs_pkg::CBS_CYC_DATA;
      end
      cbs_pkg::CBS_ST_VEC_LO: begin
        addr_d = `CBS_RST_VEC_LO;
        cyc_d = cbs_pkg::CBS_CYC_DATA;
        vp_n_d = 1'b0;
      end
      cbs_pkg::CBS_ST_VEC_HI: begin
        addr_d = `CBS_RST_VEC_HI;
        cyc_d = cbs_pkg::CBS_CYC_DATA;
        vp_n_d = 1'b0;
      end
      cbs_pkg::CBS_ST_FETCH: begin
        addr_d = ADDR_W'(pc_d);
        cyc_d = cbs_pkg::CBS_CYC_OPCODE;
      end
      cbs_pkg::CBS_ST_EXEC: begin
        if (exec_is_data) begin
          addr_d = exec_addr;
          rnw_d = ~exec_is_write;
          cyc_d = cbs_pkg::CBS_CYC_DATA;
        end else begin
          addr_d = ADDR_W'(pc_d);
          cyc_d = cbs_pkg::CBS_CYC_PROGRAM;
        end
      end
    endcase
    // the fetch indicator follows the cycle code, so the two cannot disagree
    sync_d = (cyc_d == cbs_pkg::CBS_CYC_OPCODE);
  end

  // status register: edge sets overflow regardless of stall
  // nothing here clears the flag; clearing belongs to the instruction logic
  always_comb begin
    p_d = p_q;
    if (ovf_fall) begin
      p_d[`CBS_OVF_BIT] = 1'b1;
    end
  end

  // sequencing state; reset loads constants only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= cbs_pkg::CBS_ST_IDLE;
      cnt_q <= 2'h0;
      pc_q <= 16'h0000;
      op_q <= 8'h00;
      vlo_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      pc_q <= pc_d;
      op_q <= op_d;
      vlo_q <= vlo_d;
    end
  end

  // bus pins; reset leaves an idle read with no vector pull
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_q <= '0;
      rnw_q <= 1'b1;
      cyc_q <= cbs_pkg::CBS_CYC_INTERNAL;
      sync_q <= 1'b0;
      vp_n_q <= 1'b1;
    end else begin
      addr_q <= addr_d;
      rnw_q <= rnw_d;
      cyc_q <= cyc_d;
      sync_q <= sync_d;
      vp_n_q <= vp_n_d;
    end
  end

  // status register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      p_q <= `CBS_STATUS_RESET;
    end else begin
      p_q <= p_d;
    end
  end

  // outputs straight from flops; the cycle code is split over its two pins
  assign addr = addr_q;
  assign read_not_write = rnw_q;
  assign data_address_valid = cyc_q[1];
  assign program_address_valid = cyc_q[0];
  assign opcode_fetch_indicator = sync_q;
  assign vector_pull_indicator_n = vp_n_q;
  assign program_counter = pc_q;
  assign opcode = op_q;
  assign processor_status = p_q;
endmodule : cbs_bus_ctrl

// ===== pkg/cbs_consts.svh
`ifndef CBS_CONSTS_SVH
`define CBS_CONSTS_SVH
// reset vector byte addresses
`define CBS_RST_VEC_LO 24'h00fffc
`define CBS_RST_VEC_HI 24'h00fffd
// status flag position
`define CBS_OVF_BIT 6
`define CBS_STATUS_RESET 8'h34
// start sequence: internal cycles then stack cycles before vector pull
`define CBS_INT_CYCLES 2
`define CBS_STACK_CYCLES 3
`define CBS_STACK_BASE 24'h0001ff
`endif

// ===== pkg/cbs_pkg.sv
package cbs_pkg;
  // bus cycle class, encoded {data_address_valid, program_address_valid}
  typedef enum logic [1:0] {
    CBS_CYC_INTERNAL = 2'b00,
    CBS_CYC_PROGRAM = 2'b01,
    CBS_CYC_DATA = 2'b10,
    CBS_CYC_OPCODE = 2'b11
  } cbs_cycle_t;

  typedef enum logic [2:0] {
    CBS_ST_IDLE,
    CBS_ST_INTERNAL,
    CBS_ST_STACK,
    CBS_ST_VEC_LO,
    CBS_ST_VEC_HI,
    CBS_ST_FETCH,
    CBS_ST_EXEC
  } cbs_state_t;
endpackage : cbs_pkg

// ===== src/cbs_ovf_sync.sv
`timescale 1ns/1ps
`include "cbs_consts.svh"

// synchroniser plus falling-edge detector for the overflow set pin
module cbs_ovf_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_in,
  output logic fall_pulse
);
  logic s1_q, s1_d;
  logic s2_q, s2_d;
  logic s3_q, s3_d;
  logic fall_q, fall_d;

  // only s2 and s3 are compared; s1 feeds s2 alone to limit metastability
  always_comb begin
    s1_d = pin_in;
    s2_d = s1_q;
    s3_d = s2_q;
    fall_d = s3_q & ~s2_q;
  end

  // idle level of the pin is high, so reset to ones to avoid a false edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      fall_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      fall_q <= fall_d;
    end
  end

  assign fall_pulse = fall_q;
endmodule : cbs_ovf_sync

// ===== test/cbs_bus_checker.sv
`timescale 1ns/1ps
// bus-cycle status relations seen at the ports of the controller
module cbs_bus_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic ready,
  input wire logic overflow_set_input,
  input wire logic [23:0] addr,
  input wire logic read_not_write,
  input wire logic data_address_valid,
  input wire logic program_address_valid,
  input wire logic opcode_fetch_indicator,
  input wire logic vector_pull_indicator_n,
  input wire logic [7:0] processor_status
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // the two vector reads, each taken with ready high
  sequence vec_lo_s; !vector_pull_indicator_n && addr == 24'h00fffc && ready; endsequence
  sequence vec_hi_s; !vector_pull_indicator_n && addr == 24'h00fffd && ready; endsequence
  start_internal_a: assert property (
    $past(rst) |=> (!data_address_valid && !program_address_valid)[*2])
    else $error("first cycles after reset are not internal");
  stack_read_a: assert property (
    data_address_valid && addr[23:8] == 16'h0001 |-> read_not_write)
    else $error("stack cycle wrote");
  vec_addr_a: assert property (
    !vector_pull_indicator_n |-> addr[23:1] == 23'h007ffe && read_not_write)
    else $error("vector pull off the vector pair");
  vec_order_a: assert property (vec_lo_s |=> vec_hi_s or (!ready && addr == 24'h00fffc))
    else $error("vector high byte not next");
  vec_fetch_a: assert property (vec_hi_s |=> opcode_fetch_indicator)
    else $error("no opcode fetch after vector");
  ovf_set_a: assert property ($fell(overflow_set_input) |-> ##[1:5] processor_status[6])
    else $error("overflow flag not set");
  sync_code_a: assert property (
    opcode_fetch_indicator == (data_address_valid && program_address_valid))
    else $error("opcode indicator disagrees with cycle code");
  stall_hold_a: assert property (!ready |=> $stable(addr) && $stable(opcode_fetch_indicator))
    else $error("bus moved while stalled");
  internal_quiet_a: assert property (
    !data_address_valid && !program_address_valid |-> vector_pull_indicator_n)
    else $error("vector pull in internal cycle");
  vec_data_a: assert property (
    !vector_pull_indicator_n |-> data_address_valid && !program_address_valid)
    else $error("vector read not a data cycle");
  prog_code_a: assert property (
    !data_address_valid && program_address_valid |-> !opcode_fetch_indicator && read_not_write)
    else $error("program cycle carries a stray indicator");
endmodule : cbs_bus_checker

bind cbs_bus_ctrl cbs_bus_checker i_chk (.clk, .rst, .ready, .overflow_set_input, .addr,
  .read_not_write, .data_address_valid, .program_address_valid, .opcode_fetch_indicator,
  .vector_pull_indicator_n, .processor_status);

// ===== test/cbs_mem_model.sv
`timescale 1ns/1ps
// memory side: vector bytes, fixed opcode, optional single-step hold on ready
module cbs_mem_model (
  input wire logic clk,
  input wire logic [23:0] addr,
  input wire logic data_address_valid,
  input wire logic program_address_valid,
  input wire logic opcode_fetch_indicator,
  input wire logic step_en,
  input wire logic step_go,
  output logic [7:0] data_in = 8'h5a,
  output logic ready
);
  // stepping holds ready low on opcode fetches until one step is granted
  assign ready = !(step_en && opcode_fetch_indicator && !step_go);
  // free buses toggle so stale data never passes for an answer
  always @(negedge clk) begin
    if (!data_address_valid && !program_address_valid) data_in <= ~data_in;
    else if (addr == 24'h00fffc) data_in <= 8'h34;
    else if (addr == 24'h00fffd) data_in <= 8'h12;
    else data_in <= 8'hea;
  end
endmodule : cbs_mem_model

// ===== test/test_cbs_bus_ctrl.sv
`timescale 1ns/1ps
module test_cbs_bus_ctrl;
  logic clk = 0, rst = 1, ready, overflow_set_input = 1, step_en = 0, step_go = 0;
  logic exec_is_data = 1;
  logic [7:0] data_in, opcode, processor_status;
  logic [23:0] addr;
  logic read_not_write, data_address_valid, program_address_valid;
  logic opcode_fetch_indicator, vector_pull_indicator_n;
  logic [15:0] program_counter;
  int errors = 0, comparisons = 0, cyc = 0;
  initial forever #2.5 clk = ~clk;
  cbs_mem_model i_mem (.clk, .addr, .data_address_valid, .program_address_valid,
    .opcode_fetch_indicator, .step_en, .step_go, .data_in, .ready);
  // execution stand-in: one data read per instruction, away from the stack page
  cbs_bus_ctrl i_dut (.clk, .rst, .ready, .overflow_set_input, .data_in, .exec_done(1'b1),
    .exec_is_data, .exec_is_write(1'b0), .exec_addr(24'h000345), .addr, .read_not_write,
    .data_address_valid, .program_address_valid, .opcode_fetch_indicator,
    .vector_pull_indicator_n, .program_counter, .opcode, .processor_status);
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_fetch();
    for (int n = 0; n < 40 && opcode_fetch_indicator !== 1'b1; n++) @(negedge clk);
  endtask : wait_fetch
  task automatic end_sim();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  // reset release, vector pull, then the first fetch at the vector
  task automatic test_start();
    chk("reset outs", 24'h18, {read_not_write, vector_pull_indicator_n, data_address_valid,
      program_address_valid, opcode_fetch_indicator});
    chk("reset status", 24'h34, processor_status);
    @(negedge clk) rst = 0;
    wait_fetch();
    chk("pc", 24'h001234, {8'h00, program_counter});
    chk("fetch addr", 24'h001234, addr);
    chk("fetch code", 24'h3, {data_address_valid, program_address_valid});
    $display("test_start done");
  endtask : test_start
  // falling overflow pin sets bit 6 only
  task automatic test_ovf();
    chk("flag clear", 24'h0, processor_status[6]);
    overflow_set_input = 0;
    repeat (6) @(negedge clk);
    chk("status set", 24'h74, processor_status);
    overflow_set_input = 1;
    $display("test_ovf done");
  endtask : test_ovf
  // execution cycle carries the data address with code 10
  task automatic test_data();
    @(negedge clk);
    for (int n = 0; n < 20 && data_address_valid !== 1'b1; n++) @(negedge clk);
    chk("data code", 24'h2, {data_address_valid, program_address_valid});
    chk("data addr", 24'h000345, addr);
    chk("data read", 24'h1, read_not_write);
    chk("opcode", 24'hea, opcode);
    $display("test_data done");
  endtask : test_data
  // execution cycle in program space carries code 01 at the next byte
  task automatic test_program();
    logic [23:0] a0;
    wait_fetch();
    a0 = addr;
    exec_is_data = 0;
    @(negedge clk);
    chk("prog code", 24'h2, {data_address_valid, program_address_valid,
      opcode_fetch_indicator});
    chk("prog addr", a0 + 24'h1, addr);
    exec_is_data = 1;
    $display("test_program done");
  endtask : test_program
  // single step: stalled on a fetch, one grant, stalled on the next fetch
  task automatic test_step();
    logic [23:0] a0;
    step_en = 1;
    wait_fetch();
    a0 = addr;
    repeat (5) @(negedge clk);
    chk("stall sync", 24'h1, opcode_fetch_indicator);
    step_go = 1;
    @(negedge clk) step_go = 0;
    @(negedge clk);
    wait_fetch();
    chk("step stalled", 24'h2, {opcode_fetch_indicator, ready});
    chk("step addr", a0 + 24'h1, addr);
    step_en = 0;
    $display("test_step done");
  endtask : test_step
  initial begin
    repeat (11) @(negedge clk);
    test_start();
    test_ovf();
    test_data();
    test_program();
    test_step();
    @(negedge clk) rst = 1;
    repeat (3) @(negedge clk);
    test_start();
    end_sim();
  end
  // a hang ends the run as a failure
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      end_sim();
    end
  end
endmodule : test_cbs_bus_ctrl
